// File: tscb_pkg.sv
`default_nettype none
// Shared constants and types of the timer status and interrupt combiner.
package tscb_pkg;

	// Register port widths.
	localparam int DW = 8;
	localparam int AW = 4;

	// Register byte offsets.
	localparam logic [AW-1:0] OFF_A0_ST = 4'h0;
	localparam logic [AW-1:0] OFF_A0_EN = 4'h1;
	localparam logic [AW-1:0] OFF_A1_ST = 4'h2;
	localparam logic [AW-1:0] OFF_A1_EN = 4'h3;
	localparam logic [AW-1:0] OFF_B_ST = 4'h4;
	localparam logic [AW-1:0] OFF_B_EN = 4'h5;
	localparam logic [AW-1:0] OFF_IRQ_ST = 4'h6;
	localparam logic [AW-1:0] OFF_IRQ_MSK = 4'h7;
	localparam logic [AW-1:0] OFF_INFO = 4'h8;

	// Flag and enable bit positions, shared by both timer units.
	localparam int BIT_MATCH_A = 0;
	localparam int BIT_MATCH_B = 1;
	localparam int BIT_WRAP = 2;
	localparam int NFLAG = 3;

	// Sticky interrupt status bit positions.
	localparam int IRQ_A0 = 0;
	localparam int IRQ_A1 = 1;
	localparam int IRQ_B = 2;

	// Info register bit: unit A status reads as undefined.
	localparam int INFO_UNDEF = 0;

	// Reset values.
	localparam logic [NFLAG-1:0] FLAG_RST = 3'h0;
	localparam logic [NFLAG-1:0] EN_RST = 3'h0;
	localparam logic [NFLAG-1:0] IRQ_RST = 3'h0;
	localparam logic [DW-1:0] RDATA_RST = 8'h00;
	localparam logic [15:0] CNT_RST = 16'h0000;

	// Unit B counter wrap points.
	localparam logic [15:0] CNT_MAX = 16'hffff;
	localparam logic [15:0] CNT_ZERO = 16'h0000;

	// Pattern shown for an undefined unit A status (arbitrary value).
	localparam logic [DW-1:0] UNDEF_FILL = 8'ha5;

	// One group of timer events, laid out like the status bits.
	typedef struct packed {
		logic wrap;
		logic matchB;
		logic matchA;
	} tscb_evt_t;

	// Unit A reset-value tracking.
	typedef enum logic [1:0] {
		RV_CAPTURE,
		RV_UNDEF,
		RV_VALID
	} tscb_rv_t;

endpackage
`default_nettype wire

// File: tscb_combiner.sv
// Contract
// - Writing one to a flag changes nothing.
// - Zero write keeps flag last read zero.
// - Zero write clears flag last read one.
// - Unit A status undefined under gated strap.
// - Acknowledge clears request despite pending source.
// - Next new source raises request again.
// - Unit B wrap to zero sets flag.
// - Flag newly set and enabled raises combined request.
// - Acknowledge never clears any status flag.
`timescale 1ns/1ps
`default_nettype none

// One group of three status flags, their enables and one combined request.
module tscb_flag_unit (
	// Clock, reset and freeze.
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic ce,
	// Peripheral clock gate of this group.
	input wire logic gateOn,
	// Hardware events.
	input wire tscb_pkg::tscb_evt_t evt,
	// Register access strobes and data.
	input wire logic rdSt,
	input wire logic wrSt,
	input wire logic wrEn,
	input wire logic [tscb_pkg::DW-1:0] wdata,
	// Acknowledge from the interrupt controller.
	input wire logic ack,
	// State seen by the top level.
	output logic [tscb_pkg::NFLAG-1:0] statusQ,
	output logic [tscb_pkg::NFLAG-1:0] enableQ,
	output logic request,
	output logic reqSet
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	// Flags, enables and the value of each flag as last read.
	logic [tscb_pkg::NFLAG-1:0] status_q, status_d;
	logic [tscb_pkg::NFLAG-1:0] enable_q, enable_d;
	logic [tscb_pkg::NFLAG-1:0] seen_q, seen_d;
	// Enabled-and-set flags of the previous cycle.
	logic [tscb_pkg::NFLAG-1:0] actPrev_q;
	// Combined request.
	logic request_q, request_d;

	// Events only land while the group is clocked.
	wire logic [tscb_pkg::NFLAG-1:0] evtEff = gateOn ? evt : tscb_pkg::FLAG_RST;
	// Writes only land while the group is clocked.
	wire logic wrStOk = wrSt & gateOn;
	wire logic wrEnOk = wrEn & gateOn;
	// A flag clears only where zero is written and one was read.
	wire logic [tscb_pkg::NFLAG-1:0] clrMask =
		wrStOk ? (seen_q & ~wdata[tscb_pkg::NFLAG-1:0]) : tscb_pkg::FLAG_RST;
	// Event is ORed after the clear, so it wins.
	assign status_d = (status_q & ~clrMask) | evtEff;
	// A read records each flag; a write uses the record up.
	assign seen_d = rdSt ? status_q : (wrSt ? tscb_pkg::FLAG_RST : seen_q);
	// Enable register.
	assign enable_d = wrEnOk ? wdata[tscb_pkg::NFLAG-1:0] : enable_q;
	// Sources that are set and enabled now.
	wire logic [tscb_pkg::NFLAG-1:0] active = status_q & enable_q;
	// A source that newly becomes active raises the request.
	assign reqSet = |(active & ~actPrev_q);
	// Acknowledge drops the request; an older pending source cannot re-raise it.
	assign request_d = reqSet | (request_q & ~ack);

	// Flag state; frozen while ce is low.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			status_q <= tscb_pkg::FLAG_RST;
			seen_q <= tscb_pkg::FLAG_RST;
		end else if (ce) begin
			status_q <= status_d;
			seen_q <= seen_d;
		end
	end

	// Enables, activity history and request.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			enable_q <= tscb_pkg::EN_RST;
			actPrev_q <= tscb_pkg::FLAG_RST;
			request_q <= 1'b0;
		end else if (ce) begin
			enable_q <= enable_d;
			actPrev_q <= active;
			request_q <= request_d;
		end
	end

	// Status, enable and request outputs come straight from flops; reqSet is combinational.
	assign statusQ = status_q;
	assign enableQ = enable_q;
	assign request = request_q;

	// A new, enabled event while the request is free to follow.
	sequence s_new_src;
		ce && !wrEn && (|(evtEff & enable_q & ~status_q));
	endsequence

	// The following cycle is not frozen.
	sequence s_src_lands;
		s_new_src ##1 ce;
	endsequence

	// Writing one never clears a set flag.
	a_one_write_keeps: assert property (
		ce && wrSt |=> ((~status_q & $past(status_q) & $past(wdata[tscb_pkg::NFLAG-1:0])) == 3'h0))
		else $error("a write of one cleared a flag");

	// A flag last read as zero survives a zero write.
	a_unread_zero_keeps: assert property (
		ce && wrSt |=> ((~status_q & $past(status_q) & ~$past(seen_q)) == 3'h0))
		else $error("a flag not read as one was cleared");

	// A flag last read as one is cleared by a zero write.
	a_read_one_clears: assert property (
		ce && wrSt && gateOn && !(|evt)
		|=> status_q == $past(status_q & ~(seen_q & ~wdata[tscb_pkg::NFLAG-1:0])))
		else $error("zero write did not clear a flag read as one");

	// Acknowledge drops the request unless a new source arrives.
	a_ack_drops_req: assert property (
		ce && ack && !reqSet |=> !request_q)
		else $error("request survived its acknowledge");

	// A new enabled source raises the request two cycles later.
	a_next_src_raises: assert property (
		s_src_lands |=> request_q)
		else $error("new source did not raise the request");

	// An enabled flag becoming set raises the request.
	a_pend_raises_req: assert property (
		ce && (|(active & ~$past(active))) |=> request_q)
		else $error("active source left the request low");

	// Acknowledge alone never lowers a flag.
	a_ack_keeps_flags: assert property (
		ce && ack && !wrSt |=> ((status_q & $past(status_q)) == $past(status_q)))
		else $error("acknowledge cleared a flag");

	// An event wins over a clearing write in the same cycle.
	a_set_beats_clear: assert property (
		ce && wrSt && (|evtEff) |=> ((status_q & $past(evtEff)) == $past(evtEff)))
		else $error("clearing write beat a setting event");

endmodule // tscb_flag_unit

// Status flags and combined requests of timer units A (two channels) and B.
module tscb_combiner (
	// Clock, reset and freeze.
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic ce,
	// Register port.
	input wire logic [tscb_pkg::AW-1:0] regAddr,
	input wire logic [tscb_pkg::DW-1:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [tscb_pkg::DW-1:0] regRdata,
	// Unit A channel events.
	input wire tscb_pkg::tscb_evt_t unitAEvt0,
	input wire tscb_pkg::tscb_evt_t unitAEvt1,
	// Unit B counter and compare events.
	input wire logic [15:0] unitBCount,
	input wire logic unitBMatchA,
	input wire logic unitBMatchB,
	// Clocking state of unit A.
	input wire logic oscSelectBit4,
	input wire logic unitAClockGate,
	input wire logic cpuOnHsOsc,
	// Acknowledges from the interrupt controller.
	input wire logic [1:0] unitAIrqAck,
	input wire logic unitBIrqAck,
	// Combined requests and the summary interrupt.
	output logic [1:0] unitAIrqRequest,
	output logic unitBIrqRequest,
	output logic irqOut
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	// Previous unit B count, for wrap detection.
	logic [15:0] prevCnt_q;
	// Sticky interrupt status and its mask.
	logic [tscb_pkg::NFLAG-1:0] irqSt_q, irqSt_d;
	logic [tscb_pkg::NFLAG-1:0] irqMsk_q, irqMsk_d;
	// Registered read data.
	logic [tscb_pkg::DW-1:0] rdata_q, rdata_d;
	// Unit A reset-value state.
	tscb_pkg::tscb_rv_t rv_q, rv_d;
	// Group state.
	logic [tscb_pkg::NFLAG-1:0] stA0, stA1, stB, enA0, enA1, enB;
	logic reqA0, reqA1, reqB, setA0, setA1, setB;
	// Unit B event group.
	tscb_pkg::tscb_evt_t evtB;

	// Address decode.
	wire logic selA0St = regAddr == tscb_pkg::OFF_A0_ST;
	wire logic selA0En = regAddr == tscb_pkg::OFF_A0_EN;
	wire logic selA1St = regAddr == tscb_pkg::OFF_A1_ST;
	wire logic selA1En = regAddr == tscb_pkg::OFF_A1_EN;
	wire logic selBSt = regAddr == tscb_pkg::OFF_B_ST;
	wire logic selBEn = regAddr == tscb_pkg::OFF_B_EN;
	wire logic selIrqSt = regAddr == tscb_pkg::OFF_IRQ_ST;
	wire logic selIrqMsk = regAddr == tscb_pkg::OFF_IRQ_MSK;
	wire logic selInfo = regAddr == tscb_pkg::OFF_INFO;

	// The counter stepping from its top to zero is a wrap.
	wire logic wrapEvt = (prevCnt_q == tscb_pkg::CNT_MAX) && (unitBCount == tscb_pkg::CNT_ZERO);
	assign evtB = {wrapEvt, unitBMatchB, unitBMatchA};

	// Unit A status reads as undefined until software fixes the clocking.
	wire logic undefA = rv_q != tscb_pkg::RV_VALID;

	// Unit A channel 0 flags.
	tscb_flag_unit u_unitA0 (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.ce(ce),
		.gateOn(unitAClockGate),
		.evt(unitAEvt0),
		.rdSt(regRd & selA0St),
		.wrSt(regWr & selA0St),
		.wrEn(regWr & selA0En),
		.wdata(regWdata),
		.ack(unitAIrqAck[0]),
		.statusQ(stA0),
		.enableQ(enA0),
		.request(reqA0),
		.reqSet(setA0)
	);

	// Unit A channel 1 flags.
	tscb_flag_unit u_unitA1 (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.ce(ce),
		.gateOn(unitAClockGate),
		.evt(unitAEvt1),
		.rdSt(regRd & selA1St),
		.wrSt(regWr & selA1St),
		.wrEn(regWr & selA1En),
		.wdata(regWdata),
		.ack(unitAIrqAck[1]),
		.statusQ(stA1),
		.enableQ(enA1),
		.request(reqA1),
		.reqSet(setA1)
	);

	// Unit B flags; this unit has no clock gate here.
	tscb_flag_unit u_unitB (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.ce(ce),
		.gateOn(1'b1),
		.evt(evtB),
		.rdSt(regRd & selBSt),
		.wrSt(regWr & selBSt),
		.wrEn(regWr & selBEn),
		.wdata(regWdata),
		.ack(unitBIrqAck),
		.statusQ(stB),
		.enableQ(enB),
		.request(reqB),
		.reqSet(setB)
	);

	// New requests set sticky bits; a set beats a same-cycle clear.
	wire logic [tscb_pkg::NFLAG-1:0] irqNew = {setB, setA1, setA0};
	wire logic [tscb_pkg::NFLAG-1:0] irqClr =
		(regWr & selIrqSt) ? regWdata[tscb_pkg::NFLAG-1:0] : tscb_pkg::IRQ_RST;
	assign irqSt_d = (irqSt_q & ~irqClr) | irqNew;
	assign irqMsk_d = (regWr & selIrqMsk) ? regWdata[tscb_pkg::NFLAG-1:0] : irqMsk_q;

	// Unit A status as software sees it.
	wire logic [tscb_pkg::DW-1:0] rdA0 = undefA ? tscb_pkg::UNDEF_FILL : {5'h00, stA0};
	wire logic [tscb_pkg::DW-1:0] rdA1 = undefA ? tscb_pkg::UNDEF_FILL : {5'h00, stA1};

	// Read selection; unmapped offsets read zero.
	wire logic [tscb_pkg::DW-1:0] rdSel =
		selA0St ? rdA0 :
		selA0En ? {5'h00, enA0} :
		selA1St ? rdA1 :
		selA1En ? {5'h00, enA1} :
		selBSt ? {5'h00, stB} :
		selBEn ? {5'h00, enB} :
		selIrqSt ? {5'h00, irqSt_q} :
		selIrqMsk ? {5'h00, irqMsk_q} :
		selInfo ? {7'h00, undefA} :
		tscb_pkg::RDATA_RST;
	// Data stand only in the cycle after the read strobe.
	assign rdata_d = regRd ? rdSel : tscb_pkg::RDATA_RST;

	// Reset-value tracking: the straps are caught after release; the status turns
	// defined once the gate is on and the CPU runs from the high-speed oscillator.
	always_comb begin
		rv_d = rv_q;
		case (rv_q)
			tscb_pkg::RV_CAPTURE: begin
				rv_d = (oscSelectBit4 && !unitAClockGate) ?
					tscb_pkg::RV_UNDEF : tscb_pkg::RV_VALID;
			end
			tscb_pkg::RV_UNDEF: begin
				if (unitAClockGate && cpuOnHsOsc) begin
					rv_d = tscb_pkg::RV_VALID;
				end
			end
			tscb_pkg::RV_VALID: begin
				rv_d = tscb_pkg::RV_VALID;
			end
			default: begin
				rv_d = tscb_pkg::RV_CAPTURE;
			end
		endcase
	end

	// Reset-value state and counter history.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rv_q <= tscb_pkg::RV_CAPTURE;
			prevCnt_q <= tscb_pkg::CNT_RST;
		end else if (ce) begin
			rv_q <= rv_d;
			prevCnt_q <= unitBCount;
		end
	end

	// Interrupt status, mask and read data.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			irqSt_q <= tscb_pkg::IRQ_RST;
			irqMsk_q <= tscb_pkg::IRQ_RST;
			rdata_q <= tscb_pkg::RDATA_RST;
		end else if (ce) begin
			irqSt_q <= irqSt_d;
			irqMsk_q <= irqMsk_d;
			rdata_q <= rdata_d;
		end
	end

	// Outputs.
	assign regRdata = rdata_q;
	assign unitAIrqRequest = {reqA1, reqA0};
	assign unitBIrqRequest = reqB;
	// Level interrupt while any unmasked sticky bit is set.
	assign irqOut = |(irqSt_q & irqMsk_q);

	// A wrap from top to zero sets the unit B wrap flag.
	a_wrap_sets_flag: assert property (
		ce && wrapEvt |=> stB[tscb_pkg::BIT_WRAP])
		else $error("counter wrap did not set the wrap flag");

	// Undefined unit A status reads as the fill pattern.
	a_undef_reads_fill: assert property (
		ce && regRd && selA0St && undefA |=> regRdata == tscb_pkg::UNDEF_FILL)
		else $error("undefined status did not read as fill");

endmodule // tscb_combiner
`default_nettype wire

// File: tscb_intc_model.sv
`timescale 1ns/1ps
`default_nettype none
// Stand-in for the interrupt controller: it acknowledges each raised request with one pulse.
module tscb_intc_model (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic arst_n,
	// Acknowledge switch from the bench.
	input wire logic autoAck,
	// Combined requests, bit 2 unit B, bits 1:0 unit A.
	input wire logic [2:0] irqReq,
	// One-cycle acknowledge pulses.
	output logic [2:0] irqAck
);
	// Registered acknowledge pulses.
	logic [2:0] ack_q;
	// Next pulses: one per raised request, never two in a row.
	logic [2:0] ack_d;

	// Answering is switched off by the bench while it watches a request stand.
	assign ack_d = autoAck ? (irqReq & ~ack_q) : 3'h0;
	// An acknowledge only reaches the request logic, never a status flag.
	assign irqAck = ack_q;

	// The pulse leaves just after a clock edge and lasts one cycle.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			ack_q <= 3'h0;
		end else begin
			ack_q <= ack_d;
		end
	end
endmodule // tscb_intc_model
`default_nettype wire

// File: tscb_combiner_tb.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench: register tasks on the plain port plus event pulses.
module tscb_combiner_tb;
	// Clock, reset and design inputs.
	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	logic ce = 1'b1;
	logic [3:0] regAddr = 4'h0;
	logic [7:0] regWdata = 8'h00;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	tscb_pkg::tscb_evt_t unitAEvt0 = '0;
	tscb_pkg::tscb_evt_t unitAEvt1 = '0;
	logic [15:0] unitBCount = 16'h0000;
	logic unitBMatchA = 1'b0;
	logic unitBMatchB = 1'b0;
	logic oscSelectBit4 = 1'b1;
	logic unitAClockGate = 1'b0;
	logic cpuOnHsOsc = 1'b0;
	logic autoAck = 1'b0;
	// Design outputs and partner pulses.
	logic [7:0] regRdata;
	logic [1:0] unitAIrqRequest;
	logic unitBIrqRequest;
	logic irqOut;
	logic [2:0] irqAck;
	logic [2:0] reqAll;
	// Mismatch and comparison counters.
	int n_errors = 0;
	int n_checks = 0;

	assign reqAll = {unitBIrqRequest, unitAIrqRequest};
	// The clock runs at 10 MHz.
	always #50 clk_sys = ~clk_sys;

	tscb_combiner i_dut (.clk_sys(clk_sys), .arst_n(arst_n), .ce(ce), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
		.unitAEvt0(unitAEvt0), .unitAEvt1(unitAEvt1), .unitBCount(unitBCount),
		.unitBMatchA(unitBMatchA), .unitBMatchB(unitBMatchB), .oscSelectBit4(oscSelectBit4),
		.unitAClockGate(unitAClockGate), .cpuOnHsOsc(cpuOnHsOsc), .unitAIrqAck(irqAck[1:0]),
		.unitBIrqAck(irqAck[2]), .unitAIrqRequest(unitAIrqRequest),
		.unitBIrqRequest(unitBIrqRequest), .irqOut(irqOut));

	tscb_intc_model i_intc (.clk_sys(clk_sys), .arst_n(arst_n), .autoAck(autoAck),
		.irqReq(reqAll), .irqAck(irqAck));

	// Prints the counts and the verdict, then stops the run.
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Compares one value and reports a mismatch at once.
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			$display("wrong value %s expected %h seen %h", what, exp, got);
			n_errors++;
		end
	endtask

	// One-cycle write strobe; ends just after the edge that takes it.
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge clk_sys);
		regWr <= 1'b0;
		#1;
	endtask

	// One-cycle read strobe; the data are looked at in the cycle after it.
	task automatic rdc(input logic [3:0] a, input logic [7:0] exp, input string what);
		@(posedge clk_sys);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk_sys);
		regRd <= 1'b0;
		#1;
		chk(what, exp, regRdata);
	endtask

	// One-cycle event pulses on unit A channels and unit B compares.
	task automatic pulse(input logic [2:0] a0, input logic [2:0] a1, input logic [1:0] bm);
		@(posedge clk_sys);
		unitAEvt0 <= tscb_pkg::tscb_evt_t'(a0);
		unitAEvt1 <= tscb_pkg::tscb_evt_t'(a1);
		unitBMatchA <= bm[0];
		unitBMatchB <= bm[1];
		@(posedge clk_sys);
		unitAEvt0 <= '0;
		unitAEvt1 <= '0;
		unitBMatchA <= 1'b0;
		unitBMatchB <= 1'b0;
		#1;
	endtask

	// Bounded wait for a request level; running out ends the run.
	task automatic waitReq(input int idx, input logic v, input string what);
		for (int i = 0; i < 20 && reqAll[idx] !== v; i++) begin
			@(posedge clk_sys);
			#1;
		end
		chk(what, {7'h0, v}, {7'h0, reqAll[idx]});
		if (reqAll[idx] !== v) begin
			complete_run();
		end
	endtask

	// Main sequence of tests.
	initial begin
		// Reset with the strap set and the unit A gate off.
		repeat (4) @(posedge clk_sys);
		arst_n <= 1'b1;
		rdc(tscb_pkg::OFF_A0_ST, 8'ha5, "a0 undefined");
		rdc(tscb_pkg::OFF_A1_ST, 8'ha5, "a1 undefined");
		rdc(tscb_pkg::OFF_INFO, 8'h01, "info undefined");
		unitAClockGate <= 1'b1;
		cpuOnHsOsc <= 1'b1;
		rdc(tscb_pkg::OFF_A0_ST, 8'h00, "a0 settled");
		// Address 9 is unmapped and reads zero.
		for (int a = 1; a < 10; a++) begin
			rdc(4'(a), 8'h00, "reset value");
		end
		$display("test reset done");
		// Zero writes keep flags read as zero, clear those read as one.
		rdc(tscb_pkg::OFF_A0_ST, 8'h00, "before events");
		pulse(3'h3, 3'h0, 2'h0);
		wr(tscb_pkg::OFF_A0_ST, 8'h00);
		rdc(tscb_pkg::OFF_A0_ST, 8'h03, "zero after zero read");
		wr(tscb_pkg::OFF_A0_ST, 8'hfe);
		rdc(tscb_pkg::OFF_A0_ST, 8'h02, "one kept zero cleared");
		wr(tscb_pkg::OFF_A0_ST, 8'hfd);
		pulse(3'h1, 3'h0, 2'h0);
		rdc(tscb_pkg::OFF_A0_ST, 8'h01, "reset of flag");
		// A clearing write meets a new event in the same cycle.
		fork
			wr(tscb_pkg::OFF_A0_ST, 8'h00);
			pulse(3'h1, 3'h0, 2'h0);
		join
		rdc(tscb_pkg::OFF_A0_ST, 8'h01, "event beats clear");
		wr(tscb_pkg::OFF_A0_ST, 8'hfe);
		rdc(tscb_pkg::OFF_A0_ST, 8'h00, "flag cleared");
		$display("test flags done");
		// Combined request, acknowledge with a second source pending, interrupt line.
		wr(tscb_pkg::OFF_IRQ_MSK, 8'h07);
		wr(tscb_pkg::OFF_A0_EN, 8'h07);
		pulse(3'h1, 3'h0, 2'h0);
		waitReq(0, 1'b1, "request raised");
		pulse(3'h2, 3'h0, 2'h0);
		rdc(tscb_pkg::OFF_IRQ_ST, 8'h01, "irq status");
		chk("irq line", 8'h01, {7'h0, irqOut});
		autoAck <= 1'b1;
		waitReq(0, 1'b0, "request acknowledged");
		autoAck <= 1'b0;
		repeat (5) @(posedge clk_sys);
		#1;
		chk("no re-raise", 8'h00, {7'h0, unitAIrqRequest[0]});
		rdc(tscb_pkg::OFF_A0_ST, 8'h03, "flags kept");
		wr(tscb_pkg::OFF_IRQ_MSK, 8'h00);
		chk("masked line", 8'h00, {7'h0, irqOut});
		wr(tscb_pkg::OFF_IRQ_MSK, 8'h07);
		chk("unmasked line", 8'h01, {7'h0, irqOut});
		wr(tscb_pkg::OFF_IRQ_ST, 8'h01);
		chk("cleared line", 8'h00, {7'h0, irqOut});
		wr(tscb_pkg::OFF_A0_ST, 8'hfe);
		pulse(3'h4, 3'h0, 2'h0);
		waitReq(0, 1'b1, "request again");
		autoAck <= 1'b1;
		$display("test request done");
		// Software clearing methods on channel 1, matchB disabled.
		wr(tscb_pkg::OFF_A1_EN, 8'h05);
		pulse(3'h0, 3'h3, 2'h0);
		waitReq(1, 1'b1, "a1 request raised");
		rdc(tscb_pkg::OFF_A1_ST, 8'h03, "a1 both set");
		wr(tscb_pkg::OFF_A1_ST, 8'hfc);
		rdc(tscb_pkg::OFF_A1_ST, 8'h00, "joint clear");
		pulse(3'h0, 3'h2, 2'h0);
		rdc(tscb_pkg::OFF_A1_ST, 8'h02, "disabled set");
		wr(tscb_pkg::OFF_A1_ST, 8'hfd);
		rdc(tscb_pkg::OFF_A1_ST, 8'h00, "disabled clear");
		pulse(3'h0, 3'h2, 2'h0);
		wr(tscb_pkg::OFF_A1_EN, 8'h00);
		rdc(tscb_pkg::OFF_A1_ST, 8'h02, "set again");
		wr(tscb_pkg::OFF_A1_ST, 8'h00);
		rdc(tscb_pkg::OFF_A1_ST, 8'h00, "all disabled clear");
		$display("test methods done");
		// Unit B counter wrap and compare events.
		wr(tscb_pkg::OFF_B_EN, 8'h04);
		@(posedge clk_sys);
		unitBCount <= 16'hffff;
		@(posedge clk_sys);
		unitBCount <= 16'h0000;
		waitReq(2, 1'b1, "unit b request");
		pulse(3'h0, 3'h0, 2'h3);
		rdc(tscb_pkg::OFF_B_ST, 8'h07, "wrap flag");
		// Read data stand for one cycle only.
		@(posedge clk_sys);
		#1;
		chk("read data gone", 8'h00, regRdata);
		$display("test unit b done");
		// Mid-run reset with the strap clear: status defined at once, all state cleared.
		@(posedge clk_sys);
		arst_n <= 1'b0;
		oscSelectBit4 <= 1'b0;
		repeat (2) @(posedge clk_sys);
		arst_n <= 1'b1;
		rdc(tscb_pkg::OFF_B_ST, 8'h00, "b flags after reset");
		rdc(tscb_pkg::OFF_A0_ST, 8'h00, "a0 defined");
		rdc(tscb_pkg::OFF_INFO, 8'h00, "info defined");
		chk("line after reset", 8'h00, {4'h0, irqOut, reqAll});
		// A frozen clock enable drops both an event and a write.
		@(posedge clk_sys);
		ce <= 1'b0;
		pulse(3'h0, 3'h0, 2'h3);
		wr(tscb_pkg::OFF_B_EN, 8'h07);
		@(posedge clk_sys);
		ce <= 1'b1;
		rdc(tscb_pkg::OFF_B_EN, 8'h00, "frozen write");
		rdc(tscb_pkg::OFF_B_ST, 8'h00, "frozen event");
		$display("test reset and freeze done");
		complete_run();
	end
endmodule // tscb_combiner_tb
`default_nettype wire
